// ===== hdl/cst_regs.svh
`ifndef CST_REGS_SVH
`define CST_REGS_SVH
// instruction field positions and encodings
`define CST_OP_HI 31
`define CST_OP_LO 26
`define CST_RS_HI 25
`define CST_RS_LO 21
`define CST_RT_HI 20
`define CST_RT_LO 16
`define CST_FN_HI 5
`define CST_FN_LO 0
`define CST_OP_SPECIAL 6'h00
`define CST_OP_REGISTER_IMMEDIATE_OPCLASS 6'h01
`define CST_RT_SYNC_LINE 5'h1f
`define CST_RT_TRAP_EQ_IMM 5'h0c
`define CST_FN_SYSTEM_CALL_OP 6'h0c
`define CST_FN_TRAP_EQ_REG 6'h34
// exception cause codes
`define CST_EXC_NONE 5'h00
`define CST_EXC_LOAD_TLB 5'h02
`define CST_EXC_LOAD_ADDR 5'h04
`define CST_EXC_BUS_DATA 5'h07
`define CST_EXC_SYSTEM_CALL_OP 5'h08
`define CST_EXC_RESERVED 5'h0a
`define CST_EXC_TRAP 5'h0d
`define CST_EXC_CACHE_ERR 5'h1e
// kernel region boundary: top address bit set marks kernel space
`define CST_KSEG_BIT 31
`endif

// ===== hdl/cst_pkg.sv
package cst_pkg;
  typedef logic [31:0] cst_word_t;
  typedef logic [4:0] cst_cause_t;
  typedef enum logic [1:0] {CST_RESP_OK, CST_RESP_TLB_MISS, CST_RESP_CACHE_ERR,
    CST_RESP_BUS_ERR} cst_resp_e;
endpackage

// ===== hdl/cst_line_if.sv
`timescale 1ns/1ps
`default_nettype none
// line-sync request carried from the decoder to the line sequencer
interface cst_line_if;
  logic req;
  logic [31:0] addr;
  logic global_bcast;
  logic done;
  logic [4:0] cause;
  modport dec (output req, output addr, output global_bcast, input done, input cause);
  modport seq (input req, input addr, input global_bcast, output done, output cause);
endinterface
`default_nettype wire

// ===== hdl/cst_line_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "cst_regs.svh"
// issues one cache-line sync to the hierarchy and turns its response into a cause
module cst_line_seq
  import cst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  cst_line_if.seq line,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  output logic o_mem_global,
  input wire logic i_mem_ack,
  input wire cst_pkg::cst_resp_e i_mem_resp
);
  import cst_pkg::*;
  logic busy_q;
  // -----------------------------------------------
  // request handshake towards the hierarchy
  // -----------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_q <= 1'b0;
      o_mem_addr <= 32'h0;
      o_mem_global <= 1'b0;
    end
    else if (line.req && !busy_q)
    begin
      busy_q <= 1'b1;
      o_mem_addr <= line.addr;
      o_mem_global <= line.global_bcast;
    end
    else if (busy_q && i_mem_ack)
      busy_q <= 1'b0;
  end
  assign o_mem_req = busy_q;
  // -----------------------------------------------
  // response mapping
  // -----------------------------------------------
  // a store-type miss is never reported: the hierarchy's miss becomes load-type
  always_comb
  begin
    line.done = busy_q && i_mem_ack;
    unique case (i_mem_resp)
      CST_RESP_TLB_MISS: line.cause = `CST_EXC_LOAD_TLB;
      CST_RESP_CACHE_ERR: line.cause = `CST_EXC_CACHE_ERR;
      CST_RESP_BUS_ERR: line.cause = `CST_EXC_BUS_DATA;
      CST_RESP_OK: line.cause = `CST_EXC_NONE;
    endcase
  end
endmodule // cst_line_seq
`default_nettype wire

// ===== hdl/cst_eq_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// equality of a source register with a register or a sign-extended immediate
module cst_eq_cmp
  import cst_pkg::*;
(
  input wire cst_pkg::cst_word_t i_a,
  input wire cst_pkg::cst_word_t i_b,
  input wire logic [15:0] i_imm,
  input wire logic i_use_imm,
  output logic o_equal
);
  import cst_pkg::*;
  function automatic cst_word_t sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction
  // signed equality is plain bit equality once the immediate is extended
  assign o_equal = i_use_imm ? (i_a == sext16(i_imm)) : (i_a == i_b);
endmodule // cst_eq_cmp
`default_nettype wire

// ===== hdl/cst_decode_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "cst_regs.svh"
module cst_decode_exec
  import cst_pkg::*;
#(
  parameter bit HAS_LINE_SYNC = 1'b1,
  parameter bit KSEG_ADDR_FAULT = 1'b0,
  parameter bit WATCH_ON_SYNC = 1'b0,
  parameter bit ICACHE_HW_COHERENT = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire cst_pkg::cst_word_t i_instr,
  input wire cst_pkg::cst_word_t i_src_a,
  input wire cst_pkg::cst_word_t i_src_b,
  input wire logic i_user_mode,
  input wire logic i_coherent_attr,
  input wire logic i_watch_match,
  output logic o_ready,
  output logic o_done,
  output logic o_exc,
  output cst_pkg::cst_cause_t o_exc_cause,
  output cst_pkg::cst_word_t o_bad_addr,
  output logic o_watch_hit,
  output logic o_mem_req,
  output cst_pkg::cst_word_t o_mem_addr,
  output logic o_mem_global,
  input wire logic i_mem_ack,
  input wire cst_pkg::cst_resp_e i_mem_resp
);
  import cst_pkg::*;

  typedef enum logic [0:0] {CST_IDLE, CST_WAIT} cst_state_e;

  // -----------------------------------------------
  // field decode
  // -----------------------------------------------
  logic [5:0] op_w;
  logic [4:0] rt_w;
  logic [5:0] fn_w;
  logic is_register_immediate_opclass;
  logic is_line_sync;
  logic is_teq_imm;
  logic is_system_call_op;
  logic is_teq_reg;
  cst_word_t eff_addr;
  logic eq_w;
  logic kseg_fault;

  function automatic cst_word_t sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // opcode fields; code fields of system_call_op and register trap are never read
  assign op_w = i_instr[`CST_OP_HI:`CST_OP_LO];
  assign rt_w = i_instr[`CST_RT_HI:`CST_RT_LO];
  assign fn_w = i_instr[`CST_FN_HI:`CST_FN_LO];
  assign is_register_immediate_opclass = (op_w == `CST_OP_REGISTER_IMMEDIATE_OPCLASS);
  assign is_line_sync = is_register_immediate_opclass && (rt_w == `CST_RT_SYNC_LINE);
  assign is_teq_imm = is_register_immediate_opclass && (rt_w == `CST_RT_TRAP_EQ_IMM);
  assign is_system_call_op = (op_w == `CST_OP_SPECIAL) && (fn_w == `CST_FN_SYSTEM_CALL_OP);
  assign is_teq_reg = (op_w == `CST_OP_SPECIAL) && (fn_w == `CST_FN_TRAP_EQ_REG);

  // effective address: base plus sign-extended offset, wraps modulo 2^32
  assign eff_addr = i_src_a + sext16(i_instr[15:0]);

  // kernel-space fault only checked from user mode and only if enabled;
  // i_user_mode is not a privilege gate on the sync itself
  assign kseg_fault = KSEG_ADDR_FAULT && i_user_mode && eff_addr[`CST_KSEG_BIT];

  cst_eq_cmp u_cmp (
    .i_a(i_src_a),
    .i_b(i_src_b),
    .i_imm(i_instr[15:0]),
    .i_use_imm(is_teq_imm),
    .o_equal(eq_w)
  );

  // -----------------------------------------------
  // line sequencer
  // -----------------------------------------------
  cst_line_if line_bus ();
  cst_state_e state_q;
  logic issue_w;

  // the sync is issued only when this core's icache is not kept coherent by hardware;
  // the hierarchy acts on local and shared caches and skips locked lines
  assign issue_w = i_valid && o_ready && is_line_sync && HAS_LINE_SYNC && !kseg_fault
                   && !ICACHE_HW_COHERENT;
  assign line_bus.req = issue_w;
  assign line_bus.addr = eff_addr;
  // single flag covers every level, so levels can never disagree
  assign line_bus.global_bcast = i_coherent_attr;

  cst_line_seq u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .line(line_bus.seq),
    .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr),
    .o_mem_global(o_mem_global),
    .i_mem_ack(i_mem_ack),
    .i_mem_resp(i_mem_resp)
  );

  // -----------------------------------------------
  // sequencing state
  // -----------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= CST_IDLE;
    else
    begin
      unique case (state_q)
        CST_IDLE: if (issue_w) state_q <= CST_WAIT;
        CST_WAIT: if (line_bus.done) state_q <= CST_IDLE;
      endcase
    end
  end

  // ready is registered so that it comes straight from a flip-flop
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ready <= 1'b0;
    else
      o_ready <= (state_q == CST_IDLE) ? !issue_w : line_bus.done;
  end

  // -----------------------------------------------
  // completion and exception reporting
  // -----------------------------------------------
  // one-cycle pulses; no register writeback path exists in this block
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_done <= 1'b0;
      o_exc <= 1'b0;
      o_exc_cause <= `CST_EXC_NONE;
      o_bad_addr <= 32'h0;
    end
    else
    begin
      o_done <= 1'b0;
      o_exc <= 1'b0;
      if (state_q == CST_WAIT)
      begin
        if (line_bus.done)
        begin
          o_done <= 1'b1;
          o_exc <= (line_bus.cause != `CST_EXC_NONE);
          o_exc_cause <= line_bus.cause;
          o_bad_addr <= o_mem_addr;
        end
      end
      else if (i_valid && o_ready)
      begin
        o_done <= 1'b1;
        if (is_system_call_op)
        begin
          o_exc <= 1'b1;
          o_exc_cause <= `CST_EXC_SYSTEM_CALL_OP;
        end
        else if (is_teq_reg || is_teq_imm)
        begin
          o_exc <= eq_w;
          o_exc_cause <= eq_w ? `CST_EXC_TRAP : `CST_EXC_NONE;
        end
        else if (is_line_sync && !HAS_LINE_SYNC)
        begin
          o_exc <= 1'b1;
          o_exc_cause <= `CST_EXC_RESERVED;
        end
        else if (is_line_sync && kseg_fault)
        begin
          o_exc <= 1'b1;
          o_exc_cause <= `CST_EXC_LOAD_ADDR;
          o_bad_addr <= eff_addr;
        end
        else
          o_exc_cause <= `CST_EXC_NONE;
        // hardware-coherent case: line sync completes here as a plain nop
        if (is_line_sync && HAS_LINE_SYNC && !kseg_fault && !ICACHE_HW_COHERENT)
          o_done <= 1'b0;
      end
    end
  end

  // data watch on a line-sync address is a build-time choice
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_watch_hit <= 1'b0;
    else
      o_watch_hit <= WATCH_ON_SYNC && issue_w && i_watch_match;
  end

  // the caller must follow each line sync with a barrier and hazard jump,
  // and must not sync lines it is still executing from
endmodule // cst_decode_exec
`default_nettype wire

// ===== tb/cst_decode_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// decoder port checks
// ---
module cst_decode_exec_chk
  import cst_pkg::*;
#(
  parameter bit HAS_LINE_SYNC = 1'b1,
  parameter bit KSEG_ADDR_FAULT = 1'b0,
  parameter bit WATCH_ON_SYNC = 1'b0,
  parameter bit ICACHE_HW_COHERENT = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire cst_pkg::cst_word_t i_instr,
  input wire cst_pkg::cst_word_t i_src_a,
  input wire cst_pkg::cst_word_t i_src_b,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_exc,
  input wire cst_pkg::cst_cause_t o_exc_cause,
  input wire cst_pkg::cst_word_t o_bad_addr,
  input wire logic o_watch_hit,
  input wire logic o_mem_req,
  input wire cst_pkg::cst_word_t o_mem_addr,
  input wire logic o_mem_global,
  input wire logic i_coherent_attr,
  input wire logic i_mem_ack,
  input wire cst_pkg::cst_resp_e i_mem_resp
);
  logic take, sc, trap_if_equal_reg, ti, sy, imm_eq, ack;
  cst_word_t sext, ea;
  // decode of the accepted word; sync only counts when it really goes to the hierarchy
  assign take = i_valid && o_ready;
  assign sc = i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h0c;
  assign trap_if_equal_reg = i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h34;
  assign ti = i_instr[31:26] == 6'h01 && i_instr[20:16] == 5'h0c;
  assign sy = i_instr[31:26] == 6'h01 && i_instr[20:16] == 5'h1f && HAS_LINE_SYNC
    && !ICACHE_HW_COHERENT && !KSEG_ADDR_FAULT;
  assign sext = {{16{i_instr[15]}}, i_instr[15:0]};
  assign ea = i_src_a + sext;
  assign imm_eq = i_src_a == sext;
  assign ack = o_mem_req && i_mem_ack;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_sys_call_trap: assert property (take && sc |=>
    o_done && o_exc && o_exc_cause == 5'h08)
    else $error("system call not trapped");
  chk_reg_trap_eq: assert property (take && trap_if_equal_reg && i_src_a == i_src_b |=>
    o_exc && o_exc_cause == 5'h0d)
    else $error("equal registers not trapped");
  chk_reg_trap_ne: assert property (take && trap_if_equal_reg && i_src_a != i_src_b |=>
    o_done && !o_exc)
    else $error("unequal registers trapped");
  chk_imm_trap_eq: assert property (take && ti |=> o_done && o_exc == $past(imm_eq))
    else $error("immediate compare wrong");
  chk_sync_issue: assert property (take && sy |=>
    o_mem_req && !o_ready && o_mem_addr == $past(ea))
    else $error("line sync request wrong");
  chk_sync_bcast: assert property (take && sy |=> o_mem_global == $past(i_coherent_attr))
    else $error("broadcast flag wrong");
  chk_mem_hold: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr))
    else $error("request dropped early");
  chk_tlb_load: assert property (ack && i_mem_resp == CST_RESP_TLB_MISS |=>
    o_exc && o_exc_cause == 5'h02 && o_bad_addr == $past(o_mem_addr))
    else $error("tlb miss cause wrong");
  chk_cache_err: assert property (ack && i_mem_resp == CST_RESP_CACHE_ERR |=>
    o_exc && o_exc_cause == 5'h1e)
    else $error("cache error cause wrong");
  chk_bus_err: assert property (ack && i_mem_resp == CST_RESP_BUS_ERR |=>
    o_exc && o_exc_cause == 5'h07)
    else $error("bus error cause wrong");
  chk_sync_clean: assert property (ack && i_mem_resp == CST_RESP_OK |=> o_done && !o_exc)
    else $error("clean sync faulted");
  chk_no_watch: assert property (!WATCH_ON_SYNC |-> !o_watch_hit)
    else $error("watch raised");
  cover property (take && sc);
  cover property (take && ti && imm_eq);
  cover property (ack && i_mem_resp == CST_RESP_BUS_ERR);
endmodule // cst_decode_exec_chk
`default_nettype wire

// ===== tb/cst_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cst_mem_model
  import cst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [3:0] i_delay,
  input wire cst_pkg::cst_resp_e i_resp,
  output logic o_ack,
  output cst_pkg::cst_resp_e o_resp
);
  logic [3:0] wait_q;
  // cycles an open request has waited
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wait_q <= 4'h0;
    else
      wait_q <= (i_req && !o_ack) ? wait_q + 4'h1 : 4'h0;
  end
  // no lines or cache levels are modelled here: a delay and a response code are all we show
  assign o_ack = i_req && wait_q == i_delay;
  // outside an answer the code lines carry the inverted i_resp code, never i_resp itself
  assign o_resp = o_ack ? i_resp : cst_resp_e'(~i_resp);
endmodule // cst_mem_model
`default_nettype wire

// ===== tb/cst_decode_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cst_decode_exec_bench;
  import cst_pkg::*;
  logic i_clk, i_rst_n, i_valid, i_user_mode, i_coherent_attr, i_watch_match, i_mem_ack;
  logic o_ready, o_done, o_exc, o_watch_hit, o_mem_req, o_mem_global;
  cst_word_t i_instr, i_src_a, i_src_b, o_bad_addr, o_mem_addr;
  cst_cause_t o_exc_cause;
  cst_resp_e i_mem_resp, cmd_resp;
  logic [3:0] cmd_delay;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  cst_decode_exec i_cst_decode_exec (.*);
  cst_mem_model i_cst_mem_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_mem_req),
    .i_delay(cmd_delay), .i_resp(cmd_resp), .o_ack(i_mem_ack), .o_resp(i_mem_resp));
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for ready, present one word for one take edge, then judge the answer
  task automatic run(input cst_word_t w, a, b, input bit sync, input cst_word_t ea,
    input cst_cause_t cause);
    int n = 0;
    @(posedge i_clk);
    #1;
    while (o_ready !== 1'b1 && n < 50)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    i_valid = 1'b1;
    i_instr = w;
    i_src_a = a;
    i_src_b = b;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    n = 0;
    check(o_ready, !sync);
    if (sync)
    begin
      check(o_watch_hit, 1'b0);
      check(o_mem_req, 1'b1);
      check(o_mem_addr, ea);
      check(o_mem_global, i_coherent_attr);
    end
    while (o_done !== 1'b1 && n < 50)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(n, sync ? cmd_delay + 1 : 0);
    check(o_exc, cause != 5'h00);
    check(o_exc_cause, cause);
    if (cause == 5'h02)
      check(o_bad_addr, ea);
  endtask
  task automatic t_sys_call;
    run({6'h00, 20'hfffff, 6'h0c}, 32'h0, 32'h0, 0, 32'h0, 5'h08);
    run({6'h00, 20'h00000, 6'h0c}, 32'h1, 32'h2, 0, 32'h0, 5'h08);
  endtask
  task automatic t_reg_trap;
    run({6'h00, 5'h3, 5'h4, 10'h3ff, 6'h34}, 32'h12345678, 32'h12345678, 0, 0, 5'h0d);
    run({6'h00, 5'h3, 5'h4, 10'h000, 6'h34}, 32'h12345678, 32'h12345679, 0, 0, 5'h00);
  endtask
  task automatic t_imm_trap;
    run({6'h01, 5'h2, 5'h0c, 16'h8000}, 32'hffff8000, 32'h0, 0, 0, 5'h0d);
    run({6'h01, 5'h2, 5'h0c, 16'h8000}, 32'h00008000, 32'h0, 0, 0, 5'h00);
    run({6'h01, 5'h2, 5'h0c, 16'h0005}, 32'h5, 32'h5a5a5a5a, 0, 0, 5'h0d);
  endtask
  // each response code once, slower each time, both attributes and modes
  task automatic t_line_sync;
    cst_cause_t exp [4] = '{5'h00, 5'h02, 5'h1e, 5'h07};
    for (int r = 0; r < 4; r++)
    begin
      cmd_resp = cst_resp_e'(r);
      cmd_delay = 4'(r);
      i_coherent_attr = r[0];
      i_user_mode = r[1];
      i_watch_match = 1'b1;
      // distinct lines, none holding code in flight
      run({6'h01, 5'h1, 5'h1f, 16'hfff0}, 32'h1000 + 32'(r * 64), 32'h0, 1,
        32'h0ff0 + 32'(r * 64), exp[r]);
    end
  endtask
  // timeout guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      results();
    end
  end
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_valid = 1'b0;
    i_instr = 32'h0;
    i_src_a = 32'h0;
    i_src_b = 32'h0;
    i_user_mode = 1'b0;
    i_coherent_attr = 1'b0;
    i_watch_match = 1'b0;
    cmd_delay = 4'h0;
    cmd_resp = CST_RESP_OK;
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    t_sys_call();
    t_reg_trap();
    t_imm_trap();
    t_line_sync();
    run(32'hfc000000, 32'h0, 32'h0, 0, 32'h0, 5'h00);
    results();
  end
endmodule // cst_decode_exec_bench
bind cst_decode_exec cst_decode_exec_chk #(.HAS_LINE_SYNC(HAS_LINE_SYNC),
  .KSEG_ADDR_FAULT(KSEG_ADDR_FAULT), .WATCH_ON_SYNC(WATCH_ON_SYNC),
  .ICACHE_HW_COHERENT(ICACHE_HW_COHERENT)) i_cst_decode_exec_chk (.*);
`default_nettype wire
